//--- src/ssp_consts.svh
// Named constants for the synthesiser serial control block.
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH
// Address byte: bit 7 must match the select pin, bits 6:0 are fixed (arbitrary value).
`define SSP_SEL_BIT   7
`define SSP_ADDR_LOW  7'h62
// Sub-address codes that select the target registers.
`define SSP_SUB_R     8'h01
`define SSP_SUB_N     8'h02
`define SSP_SUB_AN    8'h03
`define SSP_SUB_ST    8'h04
// Data bytes that each sub-address requires.
`define SSP_LEN_R     2'h2
`define SSP_LEN_N     2'h2
`define SSP_LEN_AN    2'h3
`define SSP_LEN_ST    2'h1
`define SSP_LEN_NONE  2'h0
// Bit counter values: last data bit of a byte and the acknowledge slot.
`define SSP_LAST_BIT  4'h7
`define SSP_ACK_SLOT  4'h8
// A STOP or repeated START always follows one lone SCL rise after the last acknowledge.
`define SSP_STOP_BIT  4'h1
// Status register bit positions.
`define SSP_SB1_BIT   0
`define SSP_SB2_BIT   1
`define SSP_POL_BIT   4
`define SSP_DBL_BIT   7
// Reset values of the programmed registers and derived enables.
`define SSP_R_RST     16'h0000
`define SSP_N_RST     12'h000
`define SSP_A_RST     7'h00
`define SSP_ST_RST    8'h00
`define SSP_RUN_RST   1'h1
`define SSP_PRE_RST   1'h1
`endif

//--- src/ssp_pkg.sv
// Types shared by the synthesiser serial control block.
package ssp_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_SUB, ST_DATA, ST_SKIP} ssp_state_e;

  // Programmed divider and status registers.
  typedef struct packed {
    logic [15:0] r_div;
    logic [11:0] n_div;
    logic [6:0]  a_div;
    logic [7:0]  status;
  } ssp_prog_s;

  // All state of the core clock domain.
  typedef struct packed {
    logic [2:0]  scl_ff, sda_ff, fc_ff, fv_ff, sel_ff, tog_ff;
    logic        scl_l, sda_l, fc_l, fv_l, sel_l, tog_l;
    ssp_state_e  state;
    logic [3:0]  bit_cnt;
    logic [1:0]  n_bytes;
    logic [7:0]  shift, sub;
    logic [23:0] data;
    logic        ack_due, sda_oe, sda_lvl;
    logic        up, dn, pd_out, pd_oe, lock_oe, lock_lvl;
    logic        cnt_run, preamp_en, dbl_en;
    ssp_prog_s   prog;
  } ssp_core_s;

  // All state of the serial clock domain.
  typedef struct packed {
    logic [1:0] rst_ff;
    logic       tog;
    logic       bit_val;
  } ssp_link_s;
endpackage

//--- src/ssp_top.sv
// Serial programming slave, phase comparator and standby control.
`timescale 1ns/10ps
`include "ssp_consts.svh"
module ssp_top
  import ssp_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        scl_clk_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  input  wire logic        addr_sel_i,
  input  wire logic        comparison_freq_i,
  input  wire logic        divided_vco_freq_i,
  output logic             phase_error_out_o,
  output logic             phase_error_out_oe_o,
  output logic             lock_pulse_out_o,
  output logic             lock_pulse_out_oe_o,
  output logic [15:0]      r_div_o,
  output logic [11:0]      n_div_o,
  output logic [6:0]       a_div_o,
  output logic [7:0]       status_o,
  output logic             counter_run_o,
  output logic             preamp_en_o,
  output logic             doubler_en_o
);

  // ****************************************
  // Helpers
  // ****************************************

  // A pin level changes once the second and third flops agree.
  function automatic logic agree(input logic [2:0] ff, input logic lvl);
    agree = (ff[1] == ff[2]) ? ff[2] : lvl;
  endfunction

  // Data bytes required by a sub-address; zero marks an unknown code.
  function automatic logic [1:0] need_bytes(input logic [7:0] sub);
    case (sub)
      `SSP_SUB_R:  need_bytes = `SSP_LEN_R;
      `SSP_SUB_N:  need_bytes = `SSP_LEN_N;
      `SSP_SUB_AN: need_bytes = `SSP_LEN_AN;
      `SSP_SUB_ST: need_bytes = `SSP_LEN_ST;
      default:     need_bytes = `SSP_LEN_NONE;
    endcase
  endfunction

  // ****************************************
  // Serial clock domain
  // ****************************************

  ssp_link_s l_reg;
  ssp_link_s l_next;

  // Each rising SCL edge samples SDA and flips a toggle for the core.
  // The sampled bit stays put until the next edge, so the core may read it.
  always_comb begin
    l_next        = l_reg;
    l_next.rst_ff = {l_reg.rst_ff[0], rst_i};
    if (l_reg.rst_ff[1]) begin
      l_next.tog     = 1'b0;
      l_next.bit_val = 1'b0;
    end else begin
      l_next.tog     = ~l_reg.tog;
      l_next.bit_val = sda_i;
    end
  end

  // Serial domain register.
  always_ff @(posedge scl_clk_i) begin
    l_reg <= l_next;
  end

  // ****************************************
  // Core clock domain
  // ****************************************

  ssp_core_s  c_reg;
  ssp_core_s  c_next;
  logic [7:0] byte_in;
  logic       bit_evt;
  logic       start;
  logic       stop;
  logic       scl_fall;
  logic       msg_ok;
  logic       commit;
  logic       fc_rise;
  logic       fv_rise;
  logic       up_n;
  logic       dn_n;

  // Whole core next-state: pin filters, serial framing, latching, comparator.
  always_comb begin
    c_next         = c_reg;
    c_next.scl_ff  = {c_reg.scl_ff[1:0], scl_i};
    c_next.sda_ff  = {c_reg.sda_ff[1:0], sda_i};
    c_next.fc_ff   = {c_reg.fc_ff[1:0], comparison_freq_i};
    c_next.fv_ff   = {c_reg.fv_ff[1:0], divided_vco_freq_i};
    c_next.sel_ff  = {c_reg.sel_ff[1:0], addr_sel_i};
    c_next.tog_ff  = {c_reg.tog_ff[1:0], l_reg.tog};
    c_next.scl_l   = agree(c_reg.scl_ff, c_reg.scl_l);
    c_next.sda_l   = agree(c_reg.sda_ff, c_reg.sda_l);
    c_next.fc_l    = agree(c_reg.fc_ff, c_reg.fc_l);
    c_next.fv_l    = agree(c_reg.fv_ff, c_reg.fv_l);
    c_next.sel_l   = agree(c_reg.sel_ff, c_reg.sel_l);
    c_next.tog_l   = agree(c_reg.tog_ff, c_reg.tog_l);
    byte_in        = {c_reg.shift[6:0], l_reg.bit_val};
    bit_evt        = c_next.tog_l != c_reg.tog_l;
    scl_fall       = c_reg.scl_l & ~c_next.scl_l;
    start          = c_reg.scl_l & c_next.scl_l & c_reg.sda_l & ~c_next.sda_l;
    stop           = c_reg.scl_l & c_next.scl_l & ~c_reg.sda_l & c_next.sda_l;
    msg_ok         = (c_reg.state == ST_DATA) && (c_reg.bit_cnt == `SSP_STOP_BIT) &&
                     (c_reg.n_bytes == need_bytes(c_reg.sub));
    commit         = (start | stop) & msg_ok;
    c_next.sda_lvl = 1'b0;

    // The acknowledge is driven from one SCL fall to the next.
    if (scl_fall) begin
      c_next.sda_oe  = c_reg.ack_due;
      c_next.ack_due = 1'b0;
    end

    // Byte assembly; the ninth clock is the acknowledge slot and is skipped.
    if (bit_evt && c_reg.state != ST_IDLE) begin
      if (c_reg.bit_cnt == `SSP_ACK_SLOT) begin
        c_next.bit_cnt = 4'h0;
      end else begin
        c_next.shift   = byte_in;
        c_next.bit_cnt = c_reg.bit_cnt + 4'h1;
        if (c_reg.bit_cnt == `SSP_LAST_BIT) begin
          case (c_reg.state)
            ST_ADDR: begin
              if (byte_in[`SSP_SEL_BIT] == c_reg.sel_l &&
                  byte_in[`SSP_SEL_BIT-1:0] == `SSP_ADDR_LOW) begin
                c_next.ack_due = 1'b1;
                c_next.state   = ST_SUB;
              end else begin
                c_next.state   = ST_SKIP;
              end
            end
            ST_SUB: begin
              c_next.sub     = byte_in;
              c_next.n_bytes = 2'h0;
              if (need_bytes(byte_in) != `SSP_LEN_NONE) begin
                c_next.ack_due = 1'b1;
                c_next.state   = ST_DATA;
              end else begin
                c_next.state   = ST_SKIP;
              end
            end
            ST_DATA: begin
              if (c_reg.n_bytes < need_bytes(c_reg.sub)) begin
                c_next.data    = {c_reg.data[15:0], byte_in};
                c_next.n_bytes = c_reg.n_bytes + 2'h1;
                c_next.ack_due = 1'b1;
              end else begin
                c_next.state   = ST_SKIP;
              end
            end
            default: c_next.ack_due = 1'b0;
          endcase
        end
      end
    end

    // Checked messages move from the data register into the latches.
    if (commit) begin
      case (c_reg.sub)
        `SSP_SUB_R:  c_next.prog.r_div = c_reg.data[15:0];
        `SSP_SUB_N:  c_next.prog.n_div = c_reg.data[11:0];
        `SSP_SUB_AN: begin
          c_next.prog.a_div = c_reg.data[22:16];
          c_next.prog.n_div = c_reg.data[11:0];
        end
        `SSP_SUB_ST: c_next.prog.status = c_reg.data[7:0];
        default:     c_next.prog = c_reg.prog;
      endcase
    end

    // START always restarts reception, even in the middle of a byte.
    if (start | stop) begin
      c_next.state   = start ? ST_ADDR : ST_IDLE;
      c_next.bit_cnt = 4'h0;
      c_next.n_bytes = 2'h0;
      c_next.ack_due = 1'b0;
      c_next.sda_oe  = 1'b0;
    end

    // Standby enables follow the latched status one cycle later.
    c_next.cnt_run   = ~c_reg.prog.status[`SSP_SB1_BIT] &
                       ~c_reg.prog.status[`SSP_SB2_BIT];
    c_next.preamp_en = ~c_reg.prog.status[`SSP_SB2_BIT];
    c_next.dbl_en    = c_reg.prog.status[`SSP_DBL_BIT] &
                       ~c_reg.prog.status[`SSP_SB2_BIT];

    // Three-state comparator; edges in the same cycle cancel, which is
    // the dead zone of one core clock.
    fc_rise = ~c_reg.fc_l & c_next.fc_l & c_reg.cnt_run;
    fv_rise = ~c_reg.fv_l & c_next.fv_l & c_reg.cnt_run;
    up_n    = c_reg.up | fc_rise;
    dn_n    = c_reg.dn | fv_rise;
    if ((up_n & dn_n) | ~c_reg.cnt_run) begin
      up_n = 1'b0;
      dn_n = 1'b0;
    end
    c_next.up       = up_n;
    c_next.dn       = dn_n;
    c_next.pd_oe    = up_n | dn_n;
    c_next.pd_out   = up_n ? c_reg.prog.status[`SSP_POL_BIT]
                           : ~c_reg.prog.status[`SSP_POL_BIT];
    c_next.lock_oe  = up_n | dn_n;
    c_next.lock_lvl = 1'b0;
  end

  // Core register; clock enable freezes all core state.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      c_reg             <= '0;
      c_reg.prog.r_div  <= `SSP_R_RST;
      c_reg.prog.n_div  <= `SSP_N_RST;
      c_reg.prog.a_div  <= `SSP_A_RST;
      c_reg.prog.status <= `SSP_ST_RST;
      c_reg.cnt_run     <= `SSP_RUN_RST;
      c_reg.preamp_en   <= `SSP_PRE_RST;
    end else if (ce_i) begin
      c_reg <= c_next;
    end
  end

  // Outputs come straight from the core register.
  assign sda_o                = c_reg.sda_lvl;
  assign sda_oe_o             = c_reg.sda_oe;
  assign phase_error_out_o    = c_reg.pd_out;
  assign phase_error_out_oe_o = c_reg.pd_oe;
  assign lock_pulse_out_o     = c_reg.lock_lvl;
  assign lock_pulse_out_oe_o  = c_reg.lock_oe;
  assign r_div_o              = c_reg.prog.r_div;
  assign n_div_o              = c_reg.prog.n_div;
  assign a_div_o              = c_reg.prog.a_div;
  assign status_o             = c_reg.prog.status;
  assign counter_run_o        = c_reg.cnt_run;
  assign preamp_en_o          = c_reg.preamp_en;
  assign doubler_en_o         = c_reg.dbl_en;

  // ****************************************
  // Checks
  // ****************************************

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i || !ce_i);

  a_pulse_start: assert property (fc_rise && !fv_rise && !c_reg.dn |=> c_reg.up)
    else $error("Comparison edge did not open a pulse.");
  a_pol_up: assert property (c_reg.pd_oe && c_reg.up |->
      c_reg.pd_out == $past(c_reg.prog.status[`SSP_POL_BIT]))
    else $error("Lead pulse has the wrong level.");
  a_pol_down: assert property (c_reg.pd_oe && c_reg.dn |->
      c_reg.pd_out != $past(c_reg.prog.status[`SSP_POL_BIT]))
    else $error("Lag pulse has the wrong level.");
  a_dead_zone: assert property (fc_rise && fv_rise && !c_reg.up && !c_reg.dn
      |=> !c_reg.pd_oe)
    else $error("Aligned edges produced a pulse.");
  a_lock_pulse: assert property (c_reg.pd_oe == c_reg.lock_oe && !c_reg.lock_lvl)
    else $error("Lock pulse does not track the phase pulse.");
  a_addr_reject: assert property (bit_evt && c_reg.state == ST_ADDR && !start && !stop &&
      c_reg.bit_cnt == `SSP_LAST_BIT && byte_in[`SSP_SEL_BIT] != c_reg.sel_l
      |=> c_reg.state == ST_SKIP && !c_reg.ack_due)
    else $error("Foreign address was accepted.");
  a_latch_hold: assert property (!commit |=> $stable(c_reg.prog))
    else $error("Latches changed without a checked message.");
  a_start_begin: assert property (start |=> c_reg.state == ST_ADDR && c_reg.bit_cnt == 4'h0)
    else $error("START did not restart reception.");
  a_stop_idle: assert property (stop |=> c_reg.state == ST_IDLE)
    else $error("STOP did not end reception.");
  a_ack_drive: assert property (scl_fall && c_reg.ack_due && !start && !stop
      |=> c_reg.sda_oe)
    else $error("Acknowledge was not driven.");
  a_standby_deep: assert property ($past(c_reg.prog.status[`SSP_SB2_BIT])
      |-> !c_reg.preamp_en && !c_reg.dbl_en && !c_reg.cnt_run)
    else $error("Deep standby left a block enabled.");
  a_doubler_on: assert property ($past(c_reg.prog.status[`SSP_DBL_BIT] &&
      !c_reg.prog.status[`SSP_SB2_BIT]) |-> c_reg.dbl_en)
    else $error("Doubler not enabled by its status bit.");

  c_commit: cover property (commit);
  c_up_pulse: cover property (c_reg.up ##1 !c_reg.up);
  c_dn_pulse: cover property (c_reg.dn ##1 !c_reg.dn);
  c_ack_slot: cover property (c_reg.sda_oe ##1 !c_reg.sda_oe);

endmodule

//--- test/ssp_master.sv
// Bus master model that programs the serial control block over SCL and SDA.
`timescale 1ns/10ps
module ssp_master (
  output logic      scl_o,
  output logic      sda_low_o,
  input  wire logic sda_i
);
  localparam int H = 400;
  logic busy_reg;

  // Bus idles with both lines released high.
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    busy_reg = 1'b0;
  end

  // Burst of link clocks; the serial side only sees reset come and go on SCL edges.
  task automatic link_reset();
    repeat (8) begin
      #15 scl_o = 1'b0;
      #15 scl_o = 1'b1;
    end
  endtask

  // One SCL period; data moves an eighth of a period after the fall, never while SCL is high.
  task automatic clk_bit(input logic b, output logic seen);
    #(H/4) sda_low_o = ~b;
    #(3*H/4) scl_o = 1'b1;
    #(H/2) seen = sda_i;
    #(H/2) scl_o = 1'b0;
  endtask

  // Sends n bytes back to back, each with an ack slot, then STOP or repeated START.
  task automatic send_msg(input logic [39:0] b, input int n, input bit rs,
                          output logic [4:0] ack);
    logic s;
    ack = 5'h0;
    if (!busy_reg) begin
      #H sda_low_o = 1'b1;
      #H scl_o = 1'b0;
    end
    for (int i = 0; i < n; i++) begin
      for (int k = 7; k >= 0; k--) clk_bit(b[32-8*i+k], s);
      clk_bit(1'b1, s);
      ack[i] = ~s;
    end
    if (rs) begin
      #(H/4) sda_low_o = 1'b0;
      #(3*H/4) scl_o = 1'b1;
      #H sda_low_o = 1'b1;
      #H scl_o = 1'b0;
      busy_reg = 1'b1;
    end else begin
      #(H/4) sda_low_o = 1'b1;
      #(3*H/4) scl_o = 1'b1;
      #H sda_low_o = 1'b0;
      #H busy_reg = 1'b0;
    end
  endtask
endmodule

//--- test/ssp_top_bench.sv
// Self-checking bench for the serial programming and phase comparator block.
`timescale 1ns/10ps
module ssp_top_bench;
  logic        core_clk, rst, sel, cf, vf;
  wire logic   scl, m_low, sda_o, sda_oe, pe_o, pe_oe, lk_o, lk_oe;
  wire logic   run, pre, dbl;
  wire logic [15:0] r_div;
  wire logic [11:0] n_div;
  wire logic [6:0]  a_div;
  wire logic [7:0]  status;
  wire logic   sda_line;
  int          error_cnt, checks_done;

  // Open-drain SDA with a pull-up: low whenever either party pulls it.
  assign sda_line = (m_low | (sda_oe & ~sda_o)) ? 1'b0 : 1'b1;

  ssp_top i_ssp_top (.core_clk_i(core_clk), .rst_i(rst), .ce_i(1'b1), .scl_clk_i(scl),
    .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe), .addr_sel_i(sel),
    .comparison_freq_i(cf), .divided_vco_freq_i(vf), .phase_error_out_o(pe_o),
    .phase_error_out_oe_o(pe_oe), .lock_pulse_out_o(lk_o), .lock_pulse_out_oe_o(lk_oe),
    .r_div_o(r_div), .n_div_o(n_div), .a_div_o(a_div), .status_o(status),
    .counter_run_o(run), .preamp_en_o(pre), .doubler_en_o(dbl));
  ssp_master i_ssp_master (.scl_o(scl), .sda_low_o(m_low), .sda_i(sda_line));

  // Core clock at 25 MHz.
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Single comparison point; four-state so an unknown never matches a known value.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // One message; acks checked per byte, then the latches are given time to load.
  task automatic wr(input logic [39:0] b, input int n, input logic [4:0] ack_exp, input bit rs);
    logic [4:0] ack;
    i_ssp_master.send_msg(b, n, rs, ack);
    chk(ack, ack_exp);
    repeat (6) @(posedge core_clk);
  endtask

  // Sub-addresses R, N and AN, each with its own byte count, land in their registers.
  task automatic t_program();
    wr(40'h6201_1234_00, 4, 5'h0f, 0);
    chk(r_div, 16'h1234);
    wr(40'h6202_abcd_00, 4, 5'h0f, 0);
    chk(n_div, 12'hbcd);
    wr(40'h6203_850f_e1, 5, 5'h1f, 0);
    chk({a_div, n_div}, {7'h05, 12'hfe1});
  endtask

  // Foreign addresses, short messages and an extra byte must leave the latches alone.
  task automatic t_refused();
    sel <= 1'b1;
    wr(40'h6201_5566_00, 4, 5'h00, 0);
    chk(r_div, 16'h1234);
    wr(40'he201_5566_00, 4, 5'h0f, 0);
    chk(r_div, 16'h5566);
    sel <= 1'b0;
    wr(40'h6201_7700_00, 3, 5'h07, 0);
    chk(r_div, 16'h5566);
    wr(40'h6204_1122_00, 4, 5'h07, 0);
    chk(status, 8'h00);
  endtask

  // A repeated START alone loads the latches and opens the next message.
  task automatic t_restart();
    wr(40'h6201_9abc_00, 4, 5'h0f, 1);
    chk(r_div, 16'h9abc);
    wr(40'h6204_1000_00, 3, 5'h07, 0);
    chk(status, 8'h10);
  endtask

  // Leader rises, the other follows gap cycles later; oe width and level are measured.
  task automatic phase(input logic cmp_first, input int gap, input logic pol, input int w_exp);
    int w;
    int lw;
    logic lv;
    w = 0;
    lw = 0;
    lv = 1'bx;
    for (int i = 0; i < gap + 12; i++) begin
      @(posedge core_clk);
      if (i == 0 && cmp_first) cf <= 1'b1;
      if (i == 0 && !cmp_first) vf <= 1'b1;
      if (i == gap) begin
        cf <= 1'b1;
        vf <= 1'b1;
      end
      #1;
      if (pe_oe === 1'b1) begin
        w++;
        lv = pe_o;
      end
      if (lk_oe === 1'b1) lw++;
    end
    chk(w, w_exp);
    chk(lw, w_exp);
    chk(lk_o, 1'b0);
    if (w_exp > 0) chk(lv, {31'h0, ~(cmp_first ^ pol)});
    @(posedge core_clk);
    cf <= 1'b0;
    vf <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask

  // Both polarities, both leaders, and the dead zone at equal edges.
  task automatic t_phase();
    phase(1'b1, 3, 1'b1, 3);
    phase(1'b0, 5, 1'b1, 5);
    phase(1'b1, 0, 1'b1, 0);
    wr(40'h6204_0000_00, 3, 5'h07, 0);
    phase(1'b1, 4, 1'b0, 4);
    phase(1'b0, 1, 1'b0, 1);
  endtask

  // Standby settings gate counters, preamplifiers and doubler; serial port keeps working.
  task automatic t_standby();
    wr(40'h6204_8100_00, 3, 5'h07, 0);
    chk({run, pre, dbl}, 3'b011);
    phase(1'b1, 3, 1'b0, 0);
    wr(40'h6204_8200_00, 3, 5'h07, 0);
    chk({run, pre, dbl}, 3'b000);
    wr(40'h6204_8000_00, 3, 5'h07, 0);
    chk({run, pre, dbl}, 3'b111);
  endtask

  // Main sequence: reset with the link clock running, then the scenarios.
  initial begin
    error_cnt = 0;
    checks_done = 0;
    rst = 1'b1;
    sel = 1'b0;
    cf = 1'b0;
    vf = 1'b0;
    i_ssp_master.link_reset();
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    i_ssp_master.link_reset();
    repeat (8) @(posedge core_clk);
    chk({run, pre, dbl, status}, {3'b110, 8'h00});
    t_program();
    t_refused();
    t_restart();
    t_phase();
    t_standby();
    end_of_test();
  end

  // Watchdog sized well beyond the expected run of about 0.4 ms.
  initial begin
    #3000000;
    error_cnt++;
    end_of_test();
  end
endmodule
